/* File: eep_pkg.sv */
// Constants, register indices and state encodings of the parallel port.
// Assumes a 10 MHz pclk and 32-bit APB with one word per register index.
package eep_pkg;

  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int EPP_TMO_NS    = 10000;
  localparam int EPP_TMO_CYC   = (EPP_TMO_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  // -----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // -----------------------------------------------------------------
  localparam int          ADDR_W   = 13;
  localparam logic [10:0] IDX_DATA = 11'h000;
  localparam logic [10:0] IDX_STAT = 11'h001;
  localparam logic [10:0] IDX_CTRL = 11'h002;
  localparam logic [10:0] IDX_EPPA = 11'h003;
  localparam logic [10:0] IDX_EPD0 = 11'h004;
  localparam logic [10:0] IDX_EPD3 = 11'h007;
  localparam logic [10:0] IDX_FIFO = 11'h400;
  localparam logic [10:0] IDX_CFGB = 11'h401;
  localparam logic [10:0] IDX_ECR  = 11'h402;
  localparam logic [10:0] IDX_PCFG = 11'h403;

  // -----------------------------------------------------------------
  // Port modes of the extended control register
  // -----------------------------------------------------------------
  localparam logic [2:0] MODE_SPP   = 3'h0;
  localparam logic [2:0] MODE_PS2   = 3'h1;
  localparam logic [2:0] MODE_COMPAT_FIFO_PORT = 3'h2;
  localparam logic [2:0] MODE_ECP   = 3'h3;
  localparam logic [2:0] MODE_EPP   = 3'h4;
  localparam logic [2:0] MODE_TEST  = 3'h6;
  localparam logic [2:0] MODE_CFG   = 3'h7;

  // -----------------------------------------------------------------
  // Field positions and fixed values
  // -----------------------------------------------------------------
  localparam int         CTL_DIR   = 5;
  localparam int         CTL_ACKIE = 4;
  localparam int         CTL_SEL   = 3;
  localparam int         CTL_INIT  = 2;
  localparam int         CTL_AFD   = 1;
  localparam int         CTL_STB   = 0;
  localparam int         STAT_TMO  = 0;
  localparam int         PCFG_EN   = 0;
  localparam int         PCFG_V19  = 1;
  localparam int         RLE_FLAG  = 7;
  localparam logic [5:0] CTL_RST   = 6'h04;
  localparam logic [7:0] CFGA_VAL  = 8'h10;
  localparam logic [7:0] CFGB_VAL  = 8'h00;

  // -----------------------------------------------------------------
  // Shared FIFO geometry
  // -----------------------------------------------------------------
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW    = 4;

  // -----------------------------------------------------------------
  // State encodings
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    EP_IDLE = 2'b00,
    EP_HOLD = 2'b01,
    EP_STRB = 2'b10
  } eep_ep_e;

  typedef enum logic [1:0] {
    DR_IDLE = 2'b00,
    DR_STB  = 2'b01,
    DR_REL  = 2'b10
  } eep_dr_e;

endpackage : eep_pkg

/* File: eep_port.sv */
// Parallel port with standard, FIFO, extended-capability and enhanced
// cycles, reached over APB. Assumes pins synchronous to pclk.
//
// Summary of operation
// - Init output low resets attached peripheral
// - Data strobe low marks enhanced data cycle
// - Address strobe low marks enhanced address cycle
// - Idle lines follow control register and direction
// - Abort enhanced cycle after ten microseconds
// - Time-out shown in status bit zero
// - Address, data write, address read, data read
// - New handshake: finish when wait returns high
// - New handshake: hold start while wait high
// - Old handshake: start anyway, end on rise
// - Sixteen byte FIFO for burst transfers
// - Run-length byte repeats following byte in hardware
// - Mode field bits 7-5 selects port mode
// - Enhanced mode needs prior configuration enable
// - Offset zero: data or address FIFO port
// - Offset 400h decodes by mode
// - Data write drives lines, read returns lines
// - Address FIFO bytes tagged, sent automatically forward
// - Status mirrors inputs, low bits read one
// - Control bits 7 and 6 read one
// - Direction bit ignored in modes 000, 010
// - Acknowledge rise raises interrupt when enabled
// - Select-in output is inverted control bit 3
// - Init direct, auto-feed and strobe inverted
// - Writing one clears the time-out bit
// - All FIFO ports share one storage
// - Standard mode resets the FIFO
//
// The implementer's own choice: the APB interface to the registers.
module eep_port
  import eep_pkg::*;
#(
  parameter int TMO_CYCLES = EPP_TMO_CYC
)(
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Data lines
  input  wire logic [7:0]        port_data_in,
  output logic      [7:0]        port_data_out,
  output logic                   port_data_oe,
  // Peripheral inputs
  input  wire logic              busy_in,
  input  wire logic              ack_in_n,
  input  wire logic              paper_error_in,
  input  wire logic              select_in,
  input  wire logic              fault_in_n,
  input  wire logic              peripheral_wait_n,
  // Peripheral outputs
  output logic                   strobe_out_n,
  output logic                   auto_feed_out_n,
  output logic                   select_in_out_n,
  output logic                   peripheral_init_n,
  output logic                   write_not_read,
  output logic                   data_strobe_n,
  output logic                   address_strobe_n,
  output logic                   ack_irq
);

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  localparam logic [7:0] TMO_M1 = 8'(TMO_CYCLES - 1);
  localparam int         TMO_A  = TMO_CYCLES + 2;

  typedef struct packed {
    logic [2:0]                  mode;
    logic [2:0]                  ecr_lo;
    logic [5:0]                  ctl;
    logic [7:0]                  data_r;
    logic                        tmo;
    logic                        epp_en;
    logic                        epp_v19;
    logic [FIFO_DEPTH-1:0][8:0]  mem;
    logic [FIFO_AW-1:0]          wp;
    logic [FIFO_AW-1:0]          rp;
    logic [FIFO_AW:0]            cnt;
    eep_ep_e                     ep;
    logic [7:0]                  ep_tmr;
    logic                        ep_low;
    logic                        ep_addr;
    logic                        ep_wr;
    logic [7:0]                  ep_wdat;
    eep_dr_e                     dr;
    logic [7:0]                  dr_byte;
    logic                        dr_cmd;
    logic [6:0]                  rle_cnt;
    logic                        pready;
    logic                        pslverr;
    logic [7:0]                  prdata;
    logic [7:0]                  pd_out;
    logic                        pd_oe;
    logic                        stb_n;
    logic                        afd_n;
    logic                        select_in_out_n_n;
    logic                        init_n;
    logic                        wnr;
    logic                        dstb_n;
    logic                        astb_n;
    logic                        irq;
    logic                        ack_d;
  } eep_state_s;

  eep_state_s  s_r;
  eep_state_s  s_nxt;
  logic [10:0] idx;
  logic        acc;
  logic        done;
  logic        epp_ok;
  logic        epp_hit;
  logic        fifo_md;
  logic        fwd;
  logic        push;
  logic        pop;
  logic [8:0]  push_val;
  logic [8:0]  head;
  logic [7:0]  rd;
  logic        err;
  logic        full;
  logic        empty;

  // Lines turn to input only where the direction bit is honoured
  function automatic logic eep_dir_in(input logic [2:0] m,
                                      input logic       d);
    eep_dir_in = d && (m != MODE_SPP) && (m != MODE_COMPAT_FIFO_PORT);
  endfunction : eep_dir_in

  // -----------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------
  assign idx     = paddr[12:2];
  assign acc     = psel && penable && !s_r.pready;
  assign done    = psel && penable && s_r.pready;
  assign epp_ok  = (s_r.mode == MODE_EPP) && s_r.epp_en;
  assign epp_hit = epp_ok && (idx >= IDX_EPPA) && (idx <= IDX_EPD3);
  assign fifo_md = (s_r.mode == MODE_COMPAT_FIFO_PORT) || (s_r.mode == MODE_ECP) ||
                   (s_r.mode == MODE_TEST);
  assign fwd     = ((s_r.mode == MODE_COMPAT_FIFO_PORT) || (s_r.mode == MODE_ECP)) &&
                   !eep_dir_in(s_r.mode, s_r.ctl[CTL_DIR]);
  assign full    = (s_r.cnt == (FIFO_AW+1)'(FIFO_DEPTH));
  assign empty   = (s_r.cnt == '0);
  assign head    = s_r.mem[s_r.rp];

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb
  begin
    s_nxt      = s_r;
    rd         = 8'h00;
    err        = 1'b0;
    push       = 1'b0;
    pop        = 1'b0;
    push_val   = 9'h000;
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    // Acknowledge rise interrupt
    s_nxt.ack_d = ack_in_n;
    s_nxt.irq   = s_r.ctl[CTL_ACKIE] && ack_in_n && !s_r.ack_d;

    // Register reads answered one cycle into the access phase
    if (acc && !epp_hit)
    begin
      s_nxt.pready = 1'b1;
      case (idx)
        IDX_DATA:
          if (s_r.mode == MODE_ECP)
            rd = 8'h00;
          else if (s_r.mode == MODE_SPP || s_r.mode == MODE_PS2 ||
                   s_r.mode == MODE_EPP)
            rd = port_data_in;
          else
            err = 1'b1;
        IDX_STAT:
          rd = {~busy_in, ack_in_n, paper_error_in, select_in,
                fault_in_n, 2'b11, epp_ok ? s_r.tmo : 1'b1};
        IDX_CTRL:
          rd = {2'b11, s_r.ctl};
        IDX_FIFO:
          if (fifo_md)
            rd = head[7:0];
          else if (s_r.mode == MODE_CFG)
            rd = CFGA_VAL;
          else
            err = 1'b1;
        IDX_CFGB:
          if (s_r.mode == MODE_CFG)
            rd = CFGB_VAL;
          else
            err = 1'b1;
        IDX_ECR:
          rd = {s_r.mode, s_r.ecr_lo, full, empty};
        IDX_PCFG:
          rd = {6'h00, s_r.epp_v19, s_r.epp_en};
        default:
          err = 1'b1;
      endcase
      s_nxt.prdata  = rd;
      s_nxt.pslverr = err;
    end

    // Writes and popping reads take effect at the completing edge
    if (done && !s_r.pslverr && pwrite)
    begin
      case (idx)
        IDX_DATA:
          if (s_r.mode == MODE_ECP)
          begin
            push     = 1'b1;
            push_val = {1'b1, pwdata[7:0]};
          end
          else
            s_nxt.data_r = pwdata[7:0];
        IDX_STAT:
          if (pwdata[STAT_TMO])
            s_nxt.tmo = 1'b0;
        IDX_CTRL:
          s_nxt.ctl = pwdata[5:0];
        IDX_FIFO:
          if (fifo_md)
          begin
            push     = 1'b1;
            push_val = {1'b0, pwdata[7:0]};
          end
        IDX_ECR:
        begin
          s_nxt.mode   = pwdata[7:5];
          s_nxt.ecr_lo = pwdata[4:2];
        end
        IDX_PCFG:
        begin
          s_nxt.epp_en  = pwdata[PCFG_EN];
          s_nxt.epp_v19 = pwdata[PCFG_V19];
        end
        default:
          s_nxt.ctl = s_r.ctl;
      endcase
    end
    if (done && !s_r.pslverr && !pwrite && idx == IDX_FIFO && !empty &&
        (s_r.mode == MODE_TEST ||
         (s_r.mode == MODE_ECP && s_r.ctl[CTL_DIR])))
      pop = 1'b1;

    // Enhanced cycle sequencer with watchdog
    case (s_r.ep)
      EP_IDLE:
        if (acc && epp_hit)
        begin
          s_nxt.ep      = EP_HOLD;
          s_nxt.ep_addr = (idx == IDX_EPPA);
          s_nxt.ep_wr   = pwrite;
          s_nxt.ep_wdat = pwdata[7:0];
          s_nxt.ep_tmr  = 8'h00;
          s_nxt.ep_low  = 1'b0;
        end
      EP_HOLD:
      begin
        s_nxt.ep_tmr = s_r.ep_tmr + 8'h01;
        if (!s_r.epp_v19 || !peripheral_wait_n)
          s_nxt.ep = EP_STRB;
      end
      EP_STRB:
      begin
        s_nxt.ep_tmr = s_r.ep_tmr + 8'h01;
        s_nxt.ep_low = s_r.ep_low || !peripheral_wait_n;
        if (peripheral_wait_n && (s_r.epp_v19 || s_r.ep_low))
        begin
          s_nxt.ep     = EP_IDLE;
          s_nxt.pready = 1'b1;
          s_nxt.prdata = s_r.ep_wr ? 8'h00 : port_data_in;
        end
      end
      default:
        s_nxt.ep = EP_IDLE;
    endcase
    if (s_r.ep != EP_IDLE && s_nxt.ep != EP_IDLE && s_r.ep_tmr == TMO_M1)
    begin
      s_nxt.ep     = EP_IDLE;
      s_nxt.tmo    = 1'b1;
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 8'hFF;
    end

    // Forward FIFO drain with run-length expansion
    case (s_r.dr)
      DR_IDLE:
        if (fwd && !empty && !busy_in)
        begin
          if (s_r.mode == MODE_ECP && head[8] && !head[RLE_FLAG])
          begin
            s_nxt.rle_cnt = head[6:0];
            pop = 1'b1;
          end
          else
          begin
            s_nxt.dr      = DR_STB;
            s_nxt.dr_byte = head[7:0];
            s_nxt.dr_cmd  = head[8] && (s_r.mode == MODE_ECP);
            if (s_r.rle_cnt != 7'h00 && !head[8])
              s_nxt.rle_cnt = s_r.rle_cnt - 7'h01;
            else
              pop = 1'b1;
          end
        end
      DR_STB:
        if (busy_in)
          s_nxt.dr = DR_REL;
      DR_REL:
        if (!busy_in)
          s_nxt.dr = DR_IDLE;
      default:
        s_nxt.dr = DR_IDLE;
    endcase
    if (!fwd)
      s_nxt.dr = DR_IDLE;

    // Shared FIFO storage
    if (s_r.mode == MODE_SPP)
    begin
      s_nxt.wp      = '0;
      s_nxt.rp      = '0;
      s_nxt.cnt     = '0;
      s_nxt.rle_cnt = 7'h00;
    end
    else
    begin
      if (push && !full)
      begin
        s_nxt.mem[s_r.wp] = push_val;
        s_nxt.wp = s_r.wp + 4'h1;
      end
      if (pop)
        s_nxt.rp = s_r.rp + 4'h1;
      s_nxt.cnt = s_r.cnt + {4'h0, push && !full} - {4'h0, pop};
    end

    // Pins from control register, then cycle overrides
    s_nxt.pd_out = s_nxt.data_r;
    s_nxt.pd_oe  = !eep_dir_in(s_nxt.mode, s_nxt.ctl[CTL_DIR]);
    s_nxt.stb_n  = !s_nxt.ctl[CTL_STB];
    s_nxt.afd_n  = !s_nxt.ctl[CTL_AFD];
    s_nxt.select_in_out_n_n = !s_nxt.ctl[CTL_SEL];
    s_nxt.init_n = s_nxt.ctl[CTL_INIT];
    if (s_nxt.dr != DR_IDLE)
    begin
      s_nxt.pd_out = s_nxt.dr_byte;
      s_nxt.pd_oe  = 1'b1;
      s_nxt.stb_n  = (s_nxt.dr != DR_STB);
      if (s_nxt.mode == MODE_ECP)
        s_nxt.afd_n = !s_nxt.dr_cmd;
    end
    if (s_nxt.ep != EP_IDLE)
    begin
      s_nxt.pd_out = s_nxt.ep_wdat;
      s_nxt.pd_oe  = s_nxt.ep_wr;
    end
    s_nxt.wnr    = !(s_nxt.ep != EP_IDLE && s_nxt.ep_wr);
    s_nxt.dstb_n = !(s_nxt.ep == EP_STRB && !s_nxt.ep_addr);
    s_nxt.astb_n = !(s_nxt.ep == EP_STRB && s_nxt.ep_addr);
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r        <= '0;
      s_r.ctl    <= CTL_RST;
      s_r.pd_oe  <= 1'b1;
      s_r.stb_n  <= 1'b1;
      s_r.afd_n  <= 1'b1;
      s_r.select_in_out_n_n <= 1'b1;
      s_r.init_n <= 1'b1;
      s_r.wnr    <= 1'b1;
      s_r.dstb_n <= 1'b1;
      s_r.astb_n <= 1'b1;
      s_r.ack_d  <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs straight from the state register
  assign prdata            = {24'h00_0000, s_r.prdata};
  assign pready            = s_r.pready;
  assign pslverr           = s_r.pslverr;
  assign port_data_out     = s_r.pd_out;
  assign port_data_oe      = s_r.pd_oe;
  assign strobe_out_n      = s_r.stb_n;
  assign auto_feed_out_n   = s_r.afd_n;
  assign select_in_out_n   = s_r.select_in_out_n_n;
  assign peripheral_init_n = s_r.init_n;
  assign write_not_read    = s_r.wnr;
  assign data_strobe_n     = s_r.dstb_n;
  assign address_strobe_n  = s_r.astb_n;
  assign ack_irq           = s_r.irq;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  a_data_strobe: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.ep == EP_STRB && !s_r.ep_addr) |-> !data_strobe_n && address_strobe_n)
    else $error("data strobe not low in data cycle");
  a_addr_strobe: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.ep == EP_STRB && s_r.ep_addr) |-> !address_strobe_n && data_strobe_n)
    else $error("address strobe not low in address cycle");
  a_cycle_bound: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s_r.ep != EP_IDLE) |-> ##[1:TMO_A] (s_r.ep == EP_IDLE))
    else $error("enhanced cycle outlived watchdog");
  a_tmo_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.ep != EP_IDLE && s_r.ep_tmr == TMO_M1 && !peripheral_wait_n) |=>
    s_r.tmo)
    else $error("time-out not flagged");
  a_v19_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.ep == EP_HOLD && s_r.epp_v19 && peripheral_wait_n) |=>
    (s_r.ep != EP_STRB))
    else $error("cycle started while wait high");
  a_ctl_ones: assert property (@(posedge pclk) disable iff (!presetn)
    (done && !pwrite && idx == IDX_CTRL) |-> prdata[7:6] == 2'b11)
    else $error("control high bits not one");
  a_select_in_out_n_inv: assert property (@(posedge pclk) disable iff (!presetn)
    (done && pwrite && !s_r.pslverr && idx == IDX_CTRL) |=>
    select_in_out_n == !$past(pwdata[CTL_SEL]))
    else $error("select-in not inverted control bit");
  a_init_stb: assert property (@(posedge pclk) disable iff (!presetn)
    (done && pwrite && idx == IDX_CTRL && s_r.mode == MODE_SPP) |=>
    peripheral_init_n == $past(pwdata[CTL_INIT]) &&
    strobe_out_n == !$past(pwdata[CTL_STB]))
    else $error("init or strobe wrong polarity");
  a_spp_out: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.mode == MODE_SPP) |-> port_data_oe)
    else $error("lines not driven in standard mode");
  a_fifo_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.mode == MODE_SPP) |=> (s_r.cnt == '0))
    else $error("fifo not reset in standard mode");
  a_ack_irq: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(ack_in_n) && s_r.ctl[CTL_ACKIE]) |=> ack_irq)
    else $error("acknowledge rise gave no interrupt");

endmodule : eep_port

/* File: eep_periph.sv */
// Peripheral model on the cable side of the parallel port.
// Assumes pins sampled on pclk; hold and stall come from the bench.
module eep_periph (
  // Clock, reset and bench controls
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       hold,
  input  wire logic       stall,
  // Cable pins
  input  wire logic       data_strobe_n,
  input  wire logic       address_strobe_n,
  input  wire logic       port_data_oe,
  input  wire logic [7:0] port_data_out,
  output logic      [7:0] port_data_in,
  output logic            peripheral_wait_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_r;
  // Counts strobe cycles; wait rises two cycles in
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= 2'h0;
    else if (data_strobe_n && address_strobe_n)
      cnt_r <= 2'h0;
    else if (!stall && cnt_r != 2'h3)
      cnt_r <= cnt_r + 2'h1;
  end
  // Low when ready, high when done
  assign peripheral_wait_n = hold || cnt_r >= 2'h2;
  // Wire level: host drive, else peripheral byte
  assign port_data_in = port_data_oe ? port_data_out : 8'ha5;
endmodule : eep_periph

/* File: eep_tb.sv */
// Self-checking bench for the parallel port over APB.
// Assumes the peripheral model answers enhanced cycles.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import eep_pkg::*;
  localparam int TMO = 8;
  logic              pclk, presetn, psel, penable, pwrite, pready;
  logic              pslverr, oe, hold, stall, err, busy, ack_n;
  logic              pe, sel, flt, wt_n, stb_n, afd_n, select_in_out_n_n, init_n;
  logic              wnr, ds_n, as_n, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [7:0]        pd_in, pd_out, rd;
  int                n_errors, n_checks;
  time               t0;
  eep_port #(.TMO_CYCLES(TMO)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_data_in(pd_in), .port_data_out(pd_out),
    .port_data_oe(oe), .busy_in(busy), .ack_in_n(ack_n),
    .paper_error_in(pe), .select_in(sel), .fault_in_n(flt),
    .peripheral_wait_n(wt_n), .strobe_out_n(stb_n),
    .auto_feed_out_n(afd_n), .select_in_out_n(select_in_out_n_n),
    .peripheral_init_n(init_n), .write_not_read(wnr),
    .data_strobe_n(ds_n), .address_strobe_n(as_n), .ack_irq(irq));
  eep_periph per_u (.pclk(pclk), .presetn(presetn), .hold(hold),
    .stall(stall), .data_strobe_n(ds_n), .address_strobe_n(as_n),
    .port_data_oe(oe), .port_data_out(pd_out), .port_data_in(pd_in),
    .peripheral_wait_n(wt_n));
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // -----------------------------------------------------------------
  // Bus and compare tasks
  // -----------------------------------------------------------------
  task automatic apb(input logic w, input logic [10:0] i,
                     input logic [7:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0000_00, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 3000);
    if (t >= 3000)
      chk1(1'b0, 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask : chk1
  // Strobe watch during an enhanced cycle
  task automatic watch(input bit dat, input logic e_wnr,
                       input logic [7:0] e_pd);
    int t;
    for (t = 0; t < 20 && (dat ? ds_n : as_n) !== 1'b0; t++)
      @(posedge pclk);
    chk1(wnr, e_wnr);
    chk8(pd_in, e_pd);
  endtask : watch
  task automatic test_done;
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_ctrl;
    apb(0, IDX_CTRL, 8'h00);
    chk8(rd, 8'hc4);
    chk8({4'h0, select_in_out_n_n, init_n, afd_n, stb_n}, 8'h0f);
    apb(1, IDX_CTRL, 8'h1f);
    apb(0, IDX_CTRL, 8'h00);
    chk8(rd, 8'hdf);
    chk8({4'h0, select_in_out_n_n, init_n, afd_n, stb_n}, 8'h04);
    apb(1, IDX_CTRL, 8'h00);
    apb(0, IDX_CTRL, 8'h00);
    chk1(init_n, 1'b0);
    chk8({4'h0, select_in_out_n_n, init_n, afd_n, stb_n}, 8'h0b);
  endtask : t_ctrl
  task automatic t_stat;
    busy <= 1'b1;
    ack_n <= 1'b0;
    pe <= 1'b1;
    sel <= 1'b0;
    flt <= 1'b1;
    apb(0, IDX_STAT, 8'h00);
    chk8(rd, 8'h2f);
    busy <= 1'b0;
    ack_n <= 1'b1;
    pe <= 1'b0;
    sel <= 1'b1;
    flt <= 1'b0;
    apb(0, IDX_STAT, 8'h00);
    chk8(rd, 8'hd7);
  endtask : t_stat
  task automatic t_data;
    apb(1, IDX_DATA, 8'h5a);
    apb(1, IDX_CTRL, 8'h24);
    chk8(pd_out, 8'h5a);
    chk1(oe, 1'b1);
    apb(1, IDX_ECR, 8'h20);
    apb(0, IDX_DATA, 8'h00);
    chk1(oe, 1'b0);
    chk8(rd, 8'ha5);
    apb(1, IDX_CTRL, 8'h14);
    ack_n <= 1'b0;
    repeat (2) @(posedge pclk);
    ack_n <= 1'b1;
    err = 1'b0;
    repeat (4) @(posedge pclk) err |= irq;
    chk1(err, 1'b1);
  endtask : t_data
  task automatic t_mode;
    apb(1, IDX_ECR, 8'he0);
    apb(0, IDX_FIFO, 8'h00);
    chk8(rd, CFGA_VAL);
    apb(1, IDX_ECR, 8'h80);
    apb(1, IDX_EPPA, 8'h12);
    chk1(err, 1'b1);
    apb(0, 11'h010, 8'h00);
    chk1(err, 1'b1);
  endtask : t_mode
  task automatic t_epp;
    apb(1, IDX_PCFG, 8'h01);
    fork
      apb(1, IDX_EPPA, 8'h12);
      watch(0, 1'b0, 8'h12);
    join
    chk8(pd_out, 8'h5a);
    fork
      apb(0, IDX_EPD0, 8'h00);
      watch(1, 1'b1, 8'ha5);
    join
    chk8(rd, 8'ha5);
    apb(1, IDX_PCFG, 8'h03);
    hold <= 1'b1;
    fork
      apb(1, IDX_EPD3, 8'h3c);
      begin
        repeat (6) @(posedge pclk) chk1(ds_n, 1'b1);
        hold <= 1'b0;
      end
    join
    chk1(err, 1'b0);
    apb(0, IDX_STAT, 8'h00);
    chk1(rd[STAT_TMO], 1'b0);
  endtask : t_epp
  task automatic t_tmo;
    stall <= 1'b1;
    t0 = $time;
    apb(1, IDX_EPD0, 8'h77);
    stall <= 1'b0;
    chk1(($time - t0) / 100 inside {[TMO : TMO + 5]}, 1'b1);
    apb(0, IDX_STAT, 8'h00);
    chk1(rd[STAT_TMO], 1'b1);
    apb(1, IDX_STAT, 8'h00);
    apb(0, IDX_STAT, 8'h00);
    chk1(rd[STAT_TMO], 1'b1);
    apb(1, IDX_STAT, 8'h01);
    apb(0, IDX_STAT, 8'h00);
    chk1(rd[STAT_TMO], 1'b0);
  endtask : t_tmo
  task automatic t_fifo;
    apb(1, IDX_ECR, 8'hc0);
    apb(1, IDX_FIFO, 8'h11);
    apb(1, IDX_FIFO, 8'h22);
    apb(0, IDX_ECR, 8'h00);
    chk8(rd, 8'hc0);
    apb(0, IDX_FIFO, 8'h00);
    chk8(rd, 8'h11);
    apb(0, IDX_FIFO, 8'h00);
    chk8(rd, 8'h22);
    apb(0, IDX_ECR, 8'h00);
    chk8(rd, 8'hc1);
    repeat (FIFO_DEPTH) apb(1, IDX_FIFO, 8'h44);
    apb(0, IDX_ECR, 8'h00);
    chk8(rd, 8'hc2);
    apb(1, IDX_ECR, 8'h00);
    apb(1, IDX_ECR, 8'hc0);
    apb(0, IDX_ECR, 8'h00);
    chk8(rd, 8'hc1);
  endtask : t_fifo
  task automatic t_ecp;
    int t;
    int k;
    apb(1, IDX_ECR, 8'h60);
    fork
      begin
        apb(1, IDX_DATA, 8'h02);
        apb(1, IDX_FIFO, 8'h5c);
        apb(1, IDX_DATA, 8'h85);
      end
      for (k = 0; k < 4; k++)
      begin
        t = 0;
        while (stb_n !== 1'b0 && t < 80)
        begin
          @(posedge pclk);
          t++;
        end
        chk8(pd_out, (k < 3) ? 8'h5c : 8'h85);
        chk1(afd_n, k != 3);
        busy <= 1'b1;
        repeat (2) @(posedge pclk);
        busy <= 1'b0;
      end
    join
  endtask : t_ecp
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, hold, stall} = 6'h00;
    {busy, pe, sel} = 3'h0;
    {ack_n, flt} = 2'h3;
    paddr = '0;
    pwdata = '0;
    n_errors = 0;
    n_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_ctrl();
    t_stat();
    t_data();
    t_mode();
    t_epp();
    t_tmo();
    t_fifo();
    t_ecp();
    test_done();
  end
  // Watchdog
  initial
  begin
    #(20000 * 100);
    n_errors++;
    test_done();
  end
endmodule : testbench
